/* core/rim_map.svh */
// register offsets, field positions and reset values of the regulator mask block
`ifndef RIM_MAP_SVH
`define RIM_MAP_SVH

// ==========================================
// offsets
`define RIM_SD_MASK_OFS 8'h22
`define RIM_LIN_MASK_OFS 8'h23

// ==========================================
// field positions inside a mask register
`define RIM_R1_FALL_BIT 7
`define RIM_R1_RISE_BIT 6
`define RIM_R1_CURLIM_BIT 4
`define RIM_R0_FALL_BIT 3
`define RIM_R0_RISE_BIT 2
`define RIM_R0_CURLIM_BIT 0

// ==========================================
// writable bits and reset values
`define RIM_MASK_WR_BITS 8'hdd
`define RIM_MASK_RESET 8'hdd

`endif

/* core/rim_pkg.sv */
// types shared by the regulator mask block
package rim_pkg;

    // ==========================================
    // register select
    typedef enum logic [1:0] {
        RIM_SEL_NONE,
        RIM_SEL_SD,
        RIM_SEL_LIN
    } rim_sel_type;

    typedef logic [7:0] rim_byte_type;

endpackage : rim_pkg

/* core/rim_mask_reg.sv */
// one 8-bit mask register with reserved bits held at zero
`timescale 1ns/100ps
`default_nettype none
`include "rim_map.svh"

module rim_mask_reg (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // write port
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] mask_q
);
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;

    always_comb begin
        mask_nxt = mask_r;
        if (wr_en) begin
            // reserved bits 5 and 1 ignore writes and stay zero
            mask_nxt = wr_data & `RIM_MASK_WR_BITS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mask_r <= `RIM_MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    assign mask_q = mask_r;
endmodule : rim_mask_reg
`default_nettype wire

/* core/rim_reg_pair.sv */
// interrupt flag logic for one pair of regulators under one mask register
`timescale 1ns/100ps
`default_nettype none
`include "rim_map.svh"

module rim_reg_pair (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // mask and live conditions
    input wire logic [7:0] mask,
    input wire logic r0_pg_raw,
    input wire logic r1_pg_raw,
    input wire logic r0_curlim_raw,
    input wire logic r1_curlim_raw,
    // flag clear pulses, one bit per flag: {r1_curlim, r1_pg, r0_curlim, r0_pg}
    input wire logic [3:0] flag_clr,
    // sticky flags, same order
    output logic [3:0] flags
);
    logic [1:0] pg_prev_r;
    logic [1:0] pg_prev_nxt;
    logic [1:0] cl_prev_r;
    logic [1:0] cl_prev_nxt;
    logic [3:0] flag_r;
    logic [3:0] flag_nxt;
    logic [3:0] set_ev;

    always_comb begin
        pg_prev_nxt = {r1_pg_raw, r0_pg_raw};
        cl_prev_nxt = {r1_curlim_raw, r0_curlim_raw};
        // raw pg is 1 when invalid: a rise means the output went bad
        set_ev[0] = (r0_pg_raw && !pg_prev_r[0] && !mask[`RIM_R0_FALL_BIT])
            || (!r0_pg_raw && pg_prev_r[0] && !mask[`RIM_R0_RISE_BIT]);
        set_ev[1] = r0_curlim_raw && !cl_prev_r[0] && !mask[`RIM_R0_CURLIM_BIT];
        set_ev[2] = (r1_pg_raw && !pg_prev_r[1] && !mask[`RIM_R1_FALL_BIT])
            || (!r1_pg_raw && pg_prev_r[1] && !mask[`RIM_R1_RISE_BIT]);
        set_ev[3] = r1_curlim_raw && !cl_prev_r[1] && !mask[`RIM_R1_CURLIM_BIT];
        // set wins over a clear arriving in the same cycle
        flag_nxt = (flag_r & ~flag_clr) | set_ev;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pg_prev_r <= 2'h0;
            cl_prev_r <= 2'h0;
            flag_r <= 4'h0;
        end else begin
            pg_prev_r <= pg_prev_nxt;
            cl_prev_r <= cl_prev_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flags = flag_r;
endmodule : rim_reg_pair
`default_nettype wire

/* core/rim_top.sv */
// regulator interrupt masking: mask registers, raw status and masked flags
//
// Contract
// - step-down mask bit 7 clear: regulator 1 going invalid sets its pg flag.
// - step-down mask bit 6 clear: regulator 1 going valid sets its pg flag.
// - step-down mask bit 4 clear: regulator 1 current limit sets its flag.
// - step-down mask bit 3 clear: regulator 0 going invalid sets its pg flag.
// - step-down mask bit 2 clear: regulator 0 going valid sets its pg flag.
// - step-down mask bit 0 clear: regulator 0 current limit sets its flag.
// - linear mask bit 7 clear: linear 1 going invalid sets its pg flag.
// - linear mask bit 6 clear: linear 1 going valid sets its pg flag.
// - linear mask bit 4 clear: linear 1 current limit sets its flag.
// - linear mask bit 3 clear: linear 0 going invalid sets its pg flag.
// - linear mask bit 2 clear: linear 0 going valid sets its pg flag.
// - linear mask bit 0 clear: linear 0 current limit sets its flag.
// - masks gate flags only; raw status always follows the live condition.
// - mask bits 5 and 1 are read-only zero; writes ignored.
// - linear raw pg reads 0 when valid, 1 when invalid.
`timescale 1ns/100ps
`default_nettype none
`include "rim_map.svh"

module rim_top
    import rim_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // live conditions, pg high while output invalid
    input wire logic sd0_pg_bad,
    input wire logic sd1_pg_bad,
    input wire logic sd0_curlim_act,
    input wire logic sd1_curlim_act,
    input wire logic lin0_pg_bad,
    input wire logic lin1_pg_bad,
    input wire logic lin0_curlim_act,
    input wire logic lin1_curlim_act,
    // flag clear pulses from the flag registers
    input wire logic [3:0] sd_flag_clr,
    input wire logic [3:0] lin_flag_clr,
    // raw status
    output logic sd0_pg_raw,
    output logic sd1_pg_raw,
    output logic sd0_curlim_raw,
    output logic sd1_curlim_raw,
    output logic lin0_pg_raw,
    output logic lin1_pg_raw,
    output logic lin0_curlim_raw,
    output logic lin1_curlim_raw,
    // masked interrupt flags
    output logic sd0_pg_irq_flag,
    output logic sd1_pg_irq_flag,
    output logic sd0_curlim_irq_flag,
    output logic sd1_curlim_irq_flag,
    output logic lin0_pg_irq_flag,
    output logic lin1_pg_irq_flag,
    output logic lin0_curlim_irq_flag,
    output logic lin1_curlim_irq_flag
);
    import rim_pkg::*;

    // ==========================================
    // decode
    rim_sel_type sel;
    logic [7:0] step_down_irq_mask;
    logic [7:0] linear_reg_irq_mask;
    logic [3:0] sd_flags;
    logic [3:0] lin_flags;
    rim_byte_type rdata_r;
    rim_byte_type rdata_nxt;
    logic [7:0] raw_r;
    logic [7:0] raw_nxt;

    always_comb begin
        case (reg_addr)
            `RIM_SD_MASK_OFS: sel = RIM_SEL_SD;
            `RIM_LIN_MASK_OFS: sel = RIM_SEL_LIN;
            default: sel = RIM_SEL_NONE;
        endcase
    end

    // ==========================================
    // mask registers
    rim_mask_reg u_sd_mask (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_en(reg_wr && sel == RIM_SEL_SD),
        .wr_data(reg_wdata),
        .mask_q(step_down_irq_mask)
    );

    rim_mask_reg u_lin_mask (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_en(reg_wr && sel == RIM_SEL_LIN),
        .wr_data(reg_wdata),
        .mask_q(linear_reg_irq_mask)
    );

    // ==========================================
    // read data, unmapped addresses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (sel)
                RIM_SEL_SD: rdata_nxt = step_down_irq_mask;
                RIM_SEL_LIN: rdata_nxt = linear_reg_irq_mask;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ==========================================
    // raw status: registered copy of the live level, never masked
    always_comb begin
        raw_nxt = {lin1_curlim_act, lin0_curlim_act, lin1_pg_bad, lin0_pg_bad,
            sd1_curlim_act, sd0_curlim_act, sd1_pg_bad, sd0_pg_bad};
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
            raw_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
            raw_r <= raw_nxt;
        end
    end

    // ==========================================
    // flag logic, edges taken from the registered raw bits
    rim_reg_pair u_sd_pair (
        .core_clk(core_clk),
        .rstn(rstn),
        .mask(step_down_irq_mask),
        .r0_pg_raw(raw_r[0]),
        .r1_pg_raw(raw_r[1]),
        .r0_curlim_raw(raw_r[2]),
        .r1_curlim_raw(raw_r[3]),
        .flag_clr(sd_flag_clr),
        .flags(sd_flags)
    );

    rim_reg_pair u_lin_pair (
        .core_clk(core_clk),
        .rstn(rstn),
        .mask(linear_reg_irq_mask),
        .r0_pg_raw(raw_r[4]),
        .r1_pg_raw(raw_r[5]),
        .r0_curlim_raw(raw_r[6]),
        .r1_curlim_raw(raw_r[7]),
        .flag_clr(lin_flag_clr),
        .flags(lin_flags)
    );

    // ==========================================
    // outputs, all from flip-flops
    assign reg_rdata = rdata_r;
    assign sd0_pg_raw = raw_r[0];
    assign sd1_pg_raw = raw_r[1];
    assign sd0_curlim_raw = raw_r[2];
    assign sd1_curlim_raw = raw_r[3];
    assign lin0_pg_raw = raw_r[4];
    assign lin1_pg_raw = raw_r[5];
    assign lin0_curlim_raw = raw_r[6];
    assign lin1_curlim_raw = raw_r[7];
    assign sd0_pg_irq_flag = sd_flags[0];
    assign sd0_curlim_irq_flag = sd_flags[1];
    assign sd1_pg_irq_flag = sd_flags[2];
    assign sd1_curlim_irq_flag = sd_flags[3];
    assign lin0_pg_irq_flag = lin_flags[0];
    assign lin0_curlim_irq_flag = lin_flags[1];
    assign lin1_pg_irq_flag = lin_flags[2];
    assign lin1_curlim_irq_flag = lin_flags[3];
endmodule : rim_top
`default_nettype wire

/* verification/rim_top_monitor.sv */
// assertion checker for the regulator mask block
`timescale 1ns/100ps
`default_nettype none
module rim_top_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // watched status and flags
    input wire logic sd0_pg_bad,
    input wire logic sd0_pg_raw,
    input wire logic lin1_pg_bad,
    input wire logic lin1_pg_raw,
    input wire logic lin0_curlim_raw,
    input wire logic [3:0] sd_flag_clr,
    input wire logic sd0_pg_irq_flag,
    input wire logic lin0_curlim_irq_flag
);
    logic [7:0] sd_m_r;
    logic [7:0] sd_m_nxt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ====================
    // shadow mask, needed because the mask is not visible at the ports
    always_comb sd_m_nxt = (reg_wr && reg_addr == 8'h22) ? reg_wdata : sd_m_r;
    always_ff @(posedge core_clk) sd_m_r <= rstn ? sd_m_nxt : 8'hdd;
    // ====================
    // properties
    a_sd_raw_follow: assert property (1'b1 |=> sd0_pg_raw == $past(sd0_pg_bad))
        else $error("sd0 raw pg lags");
    a_lin_raw_follow: assert property (1'b1 |=> lin1_pg_raw == $past(lin1_pg_bad))
        else $error("lin1 raw pg lags");
    a_rsv_read_zero: assert property (reg_rd |=> !reg_rdata[5] && !reg_rdata[1])
        else $error("reserved bit reads one");
    a_pg_set_cause: assert property ($rose(sd0_pg_irq_flag) |->
        $past(sd0_pg_raw) != $past(sd0_pg_raw, 2))
        else $error("pg flag set without raw change");
    a_pg_set_masked: assert property ($rose(sd0_pg_irq_flag) |->
        ($past(sd0_pg_raw) ? !$past(sd_m_r[3]) : !$past(sd_m_r[2])))
        else $error("masked pg event set flag");
    a_cl_set_cause: assert property ($rose(lin0_curlim_irq_flag) |->
        $past(lin0_curlim_raw) && !$past(lin0_curlim_raw, 2))
        else $error("curlim flag set without rise");
    a_flag_holds: assert property (sd0_pg_irq_flag && !sd_flag_clr[0] |=> sd0_pg_irq_flag)
        else $error("pg flag dropped");
    a_flag_clears: assert property (sd0_pg_irq_flag && sd_flag_clr[0] &&
        sd0_pg_raw == $past(sd0_pg_raw) |=> !sd0_pg_irq_flag)
        else $error("pg flag not cleared");
    c_pg_set: cover property ($rose(sd0_pg_irq_flag));
    c_cl_set: cover property ($rose(lin0_curlim_irq_flag));
    c_lin_read: cover property (reg_rd && reg_addr == 8'h23);
endmodule : rim_top_monitor
bind rim_top rim_top_monitor u_rim_top_monitor (.core_clk, .rstn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .sd0_pg_bad, .sd0_pg_raw, .lin1_pg_bad, .lin1_pg_raw,
    .lin0_curlim_raw, .sd_flag_clr, .sd0_pg_irq_flag, .lin0_curlim_irq_flag);
`default_nettype wire

/* verification/rim_top_tb.sv */
// self-checking testbench for the regulator mask block
`timescale 1ns/100ps
`default_nettype none
module rim_top_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    // index 0 step-down, 1 linear; bits {r1 curlim, r1 pg, r0 curlim, r0 pg}
    logic [1:0][3:0] live = '0;
    logic [1:0][3:0] clr = '0;
    // nets, since every bit is driven by its own design port
    wire logic [1:0][3:0] raw;
    wire logic [1:0][3:0] flg;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    always #2 core_clk = ~core_clk;
    rim_top u_rim_top (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .sd0_pg_bad(live[0][0]), .sd0_curlim_act(live[0][1]), .sd1_pg_bad(live[0][2]),
        .sd1_curlim_act(live[0][3]), .lin0_pg_bad(live[1][0]), .lin0_curlim_act(live[1][1]),
        .lin1_pg_bad(live[1][2]), .lin1_curlim_act(live[1][3]), .sd_flag_clr(clr[0]),
        .lin_flag_clr(clr[1]), .sd0_pg_raw(raw[0][0]), .sd0_curlim_raw(raw[0][1]),
        .sd1_pg_raw(raw[0][2]), .sd1_curlim_raw(raw[0][3]), .lin0_pg_raw(raw[1][0]),
        .lin0_curlim_raw(raw[1][1]), .lin1_pg_raw(raw[1][2]), .lin1_curlim_raw(raw[1][3]),
        .sd0_pg_irq_flag(flg[0][0]), .sd0_curlim_irq_flag(flg[0][1]),
        .sd1_pg_irq_flag(flg[0][2]), .sd1_curlim_irq_flag(flg[0][3]),
        .lin0_pg_irq_flag(flg[1][0]), .lin0_curlim_irq_flag(flg[1][1]),
        .lin1_pg_irq_flag(flg[1][2]), .lin1_curlim_irq_flag(flg[1][3]));
    // ====================
    // tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    task rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(reg_rdata, e);
    endtask : rd
    task pulse_clr(input logic s, input int k);
        clr[s][k] = 1'b1;
        @(negedge core_clk);
        clr[s][k] = 1'b0;
    endtask : pulse_clr
    // bad then good on one live input under mask m
    task ev(input logic s, input int k, input logic [7:0] m, input logic eb, input logic eg);
        acc(1'b1, {7'h11, s}, m);
        live[s][k] = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({7'h0, raw[s][k]}, 8'h01);
        chk({7'h0, flg[s][k]}, {7'h0, eb});
        pulse_clr(s, k);
        live[s][k] = 1'b0;
        repeat (3) @(negedge core_clk);
        chk({7'h0, raw[s][k]}, 8'h00);
        chk({7'h0, flg[s][k]}, {7'h0, eg});
        pulse_clr(s, k);
    endtask : ev
    task wrap_up;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    // ====================
    // sequence
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            wrap_up;
        end
    end
    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        chk(flg, 8'h00);
        rd(8'h22, 8'hdd);
        rd(8'h23, 8'hdd);
        rd(8'h24, 8'h00);
        for (int s = 0; s < 2; s++) begin
            acc(1'b1, {7'h11, s[0]}, 8'hff);
            rd({7'h11, s[0]}, 8'hdd);
            ev(s[0], 0, 8'h08, 1'b0, 1'b1);
            ev(s[0], 0, 8'h04, 1'b1, 1'b0);
            ev(s[0], 1, 8'h01, 1'b0, 1'b0);
            ev(s[0], 1, 8'h00, 1'b1, 1'b0);
            ev(s[0], 2, 8'h80, 1'b0, 1'b1);
            ev(s[0], 2, 8'h40, 1'b1, 1'b0);
            ev(s[0], 3, 8'h10, 1'b0, 1'b0);
            ev(s[0], 3, 8'h00, 1'b1, 1'b0);
            rd({7'h11, s[0]}, 8'h00);
        end
        // set and clear in one cycle: the set must win
        acc(1'b1, 8'h22, 8'h00);
        live[0][1] = 1'b1;
        @(negedge core_clk);
        clr[0][1] = 1'b1;
        @(negedge core_clk);
        chk({7'h0, flg[0][1]}, 8'h01);
        @(negedge core_clk);
        clr[0][1] = 1'b0;
        chk({7'h0, flg[0][1]}, 8'h00);
        live[0][1] = 1'b0;
        // mid-run reset brings masks and flags back to their reset state
        live[0][0] = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({7'h0, flg[0][0]}, 8'h01);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        chk(flg, 8'h00);
        rd(8'h22, 8'hdd);
        rd(8'h23, 8'hdd);
        chk({7'h0, raw[0][0]}, 8'h01);
        chk(flg, 8'h00);
        live[0][0] = 1'b0;
        repeat (3) @(negedge core_clk);
        chk(flg, 8'h00);
        wrap_up;
    end
endmodule : rim_top_tb
`default_nettype wire
